/* File: logic/sfrl_host.sv */
`timescale 1ns/1ps
module sfrl_host
    import sfrl_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire sfrl_cmd_e cmd_in,
    input wire logic [31:0] addr_in,
    input wire logic [7:0] nbytes_in,
    input wire logic qpi_in,
    input wire logic [3:0] lat_code_in,
    input wire logic [1:0] reg_lat_in,
    output logic busy_out,
    output logic refused_out,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic done_out,
    sfrl_link_if.host link
);

    typedef enum {SFRL_H_IDLE, SFRL_H_RUN, SFRL_H_TAIL} sfrl_hst_e;

    sfrl_hst_e st_q;
    logic [3:0] dq_s1_q;
    logic [3:0] dq_s2_q;
    logic [3:0] hc_q;
    logic tick;
    sfrl_cmd_e cmd_q;
    logic qpi_q;
    logic [7:0] lat_q;
    logic [11:0] nbeats_q;
    logic [11:0] fc_q;
    logic [39:0] sh_q;
    logic [39:0] sh_nx;
    logic [7:0] rx_q;
    logic [7:0] rx_nx;
    logic last_q;
    logic quad;
    logic [11:0] c_end;
    logic [11:0] a_end;
    logic [11:0] m_end;
    logic [11:0] l_end;
    logic [11:0] beat;
    logic [11:0] fn;
    logic refuse;
    logic [7:0] nb;
    logic [7:0] op_in;

    assign tick = hc_q == 4'(SFRL_SCK_HALF - 1);
    assign quad = sfrl_quad(cmd_q, qpi_q);
    assign c_end = {4'h0, sfrl_cmd_cyc(qpi_q)};
    assign a_end = c_end + {4'h0, sfrl_addr_cyc(cmd_q, qpi_q)};
    assign m_end = a_end + {4'h0, sfrl_mode_cyc(cmd_q, qpi_q)};
    assign l_end = m_end + {4'h0, lat_q};
    // Device launches beat 0 on the rise after latency; it is taken a rise later
    assign beat = fc_q - l_end - 12'h001;
    assign op_in = sfrl_opcode(cmd_in);
    assign fn = fc_q + 12'h001;
    assign sh_nx = ((fc_q < c_end) ? qpi_q : quad) ? {sh_q[35:0], 4'h0} : {sh_q[38:0], 1'b0};
    assign rx_nx = quad ? {rx_q[3:0], dq_s2_q} : {rx_q[6:0], dq_s2_q[1]};
    assign nb = (nbytes_in < SFRL_MIN_BYTES) ? SFRL_MIN_BYTES : nbytes_in;

    // Clock ceiling, quad I/O clock per latency code, secure quad latency
    assign refuse = SFRL_SCK_MHZ > SFRL_SDR_MAX_MHZ
                    || cmd_in == SFRL_C_BAD
                    || (cmd_in == SFRL_C_QIO
                        && int'(SFRL_QIO_MHZ[lat_code_in]) < SFRL_SCK_MHZ)
                    || (cmd_in == SFRL_C_SECQ && qpi_in && lat_code_in == 4'h0);

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            dq_s1_q <= 4'h0;
            dq_s2_q <= 4'h0;
        end else begin
            dq_s1_q <= link.dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame sequencer; the link clock is this clock divided down

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            st_q <= SFRL_H_IDLE;
            busy_out <= 1'b0;
            refused_out <= 1'b0;
            done_out <= 1'b0;
            hc_q <= 4'h0;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.dq_h <= 4'h0;
            link.dq_h_oe <= 4'h0;
            cmd_q <= SFRL_C_BAD;
            qpi_q <= 1'b0;
            lat_q <= 8'h00;
            nbeats_q <= 12'h000;
            fc_q <= 12'h000;
            sh_q <= 40'h00_0000_0000;
        end else begin
            refused_out <= 1'b0;
            done_out <= 1'b0;
            case (st_q)
                SFRL_H_IDLE: begin
                    hc_q <= 4'h0;
                    if (start_in && refuse) begin
                        refused_out <= 1'b1;
                    end else if (start_in) begin
                        st_q <= SFRL_H_RUN;
                        busy_out <= 1'b1;
                        link.cs_n <= 1'b0;
                        cmd_q <= cmd_in;
                        qpi_q <= qpi_in;
                        lat_q <= sfrl_lat_cyc(cmd_in, lat_code_in, reg_lat_in,
                                              addr_in[SFRL_VOL_BIT]);
                        nbeats_q <= sfrl_quad(cmd_in, qpi_in) ? {3'h0, nb, 1'b0}
                                                               : {1'b0, nb, 3'h0};
                        fc_q <= 12'h000;
                        sh_q <= {sfrl_opcode(cmd_in), addr_in};
                        link.dq_h <= qpi_in ? op_in[7:4] : {3'h0, op_in[7]};
                        link.dq_h_oe <= qpi_in ? 4'hf : 4'h1;
                    end
                end
                SFRL_H_RUN: begin
                    hc_q <= tick ? 4'h0 : hc_q + 4'h1;
                    if (tick) begin
                        link.sck <= ~link.sck;
                    end
                    if (tick && link.sck && last_q) begin
                        st_q <= SFRL_H_TAIL;
                        link.cs_n <= 1'b1;
                        link.dq_h_oe <= 4'h0;
                        done_out <= 1'b1;
                    end else if (tick && link.sck) begin
                        fc_q <= fn;
                        sh_q <= sh_nx;
                        if (fn < c_end) begin
                            link.dq_h <= qpi_q ? sh_nx[39:36] : {3'h0, sh_nx[39]};
                            link.dq_h_oe <= qpi_q ? 4'hf : 4'h1;
                        end else if (fn < a_end) begin
                            link.dq_h <= quad ? sh_nx[39:36] : {3'h0, sh_nx[39]};
                            link.dq_h_oe <= quad ? 4'hf : 4'h1;
                        end else if (fn < m_end) begin
                            // No continuous-read mode: mode cycles carry zero
                            link.dq_h <= 4'h0;
                            link.dq_h_oe <= quad ? 4'hf : 4'h1;
                        end else begin
                            link.dq_h_oe <= 4'h0;
                        end
                    end
                end
                default: begin
                    // Chip select high long enough for the far end to see it
                    hc_q <= hc_q + 4'h1;
                    if (hc_q == SFRL_CS_HIGH_CYC) begin
                        st_q <= SFRL_H_IDLE;
                        busy_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path, sampled where the link clock rises

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            rx_q <= 8'h00;
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
            last_q <= 1'b0;
        end else begin
            rx_valid_out <= 1'b0;
            if (st_q != SFRL_H_RUN) begin
                last_q <= 1'b0;
            end else if (tick && !link.sck && fc_q > l_end && !last_q) begin
                rx_q <= rx_nx;
                if (quad ? beat[0] : beat[2:0] == 3'h7) begin
                    rx_valid_out <= 1'b1;
                    rx_data_out <= rx_nx;
                end
                if (beat == nbeats_q - 12'h001) begin
                    last_q <= 1'b1;
                end
            end
        end
    end

endmodule

/* File: logic/sfrl_pkg.sv */
package sfrl_pkg;

    localparam int SFRL_REF_MHZ = 200;
    localparam int SFRL_SCK_HALF = 2;
    localparam int SFRL_SCK_MHZ = SFRL_REF_MHZ / (2 * SFRL_SCK_HALF);
    localparam int SFRL_SDR_MAX_MHZ = 166;
    localparam int SFRL_DDR_MAX_MHZ = 102;
    localparam logic [3:0] SFRL_CS_HIGH_CYC = 4'h8;

    localparam logic [7:0] SFRL_OP_FAST4 = 8'h0c;
    localparam logic [7:0] SFRL_OP_QIO = 8'heb;
    localparam logic [7:0] SFRL_OP_REG = 8'h65;
    localparam logic [7:0] SFRL_OP_SFDP = 8'h5a;
    localparam logic [7:0] SFRL_OP_UID = 8'h4c;
    localparam logic [7:0] SFRL_OP_SECQ = 8'h4b;

    localparam logic [3:0] SFRL_LAT_RST = 4'h8;
    localparam logic [1:0] SFRL_REGLAT_RST = 2'h0;
    localparam logic SFRL_QPI_RST = 1'b0;
    localparam logic [7:0] SFRL_SFDP_DUMMY = 8'h08;
    localparam logic [7:0] SFRL_UID_LAT = 8'h20;
    localparam logic [7:0] SFRL_MODE_SINGLE = 8'h08;
    localparam logic [7:0] SFRL_MODE_QUAD = 8'h02;
    localparam logic [7:0] SFRL_MIN_BYTES = 8'h02;
    localparam int SFRL_VOL_BIT = 23;

    // Highest quad I/O clock in MHz per latency code
    localparam logic [7:0] SFRL_QIO_MHZ [16] = '{
        8'h2b, 8'h38, 8'h44, 8'h51, 8'h5d, 8'h6a, 8'h76, 8'h83,
        8'h8f, 8'h9c, 8'ha6, 8'ha6, 8'ha6, 8'ha6, 8'ha6, 8'ha6};

    typedef enum logic [2:0] {
        SFRL_C_FAST4, SFRL_C_QIO, SFRL_C_REG, SFRL_C_SFDP, SFRL_C_UID, SFRL_C_SECQ, SFRL_C_BAD
    } sfrl_cmd_e;

    function automatic sfrl_cmd_e sfrl_decode(logic [7:0] op);
        case (op)
            SFRL_OP_FAST4: return SFRL_C_FAST4;
            SFRL_OP_QIO: return SFRL_C_QIO;
            SFRL_OP_REG: return SFRL_C_REG;
            SFRL_OP_SFDP: return SFRL_C_SFDP;
            SFRL_OP_UID: return SFRL_C_UID;
            SFRL_OP_SECQ: return SFRL_C_SECQ;
            default: return SFRL_C_BAD;
        endcase
    endfunction

    function automatic logic [7:0] sfrl_opcode(sfrl_cmd_e c);
        case (c)
            SFRL_C_FAST4: return SFRL_OP_FAST4;
            SFRL_C_QIO: return SFRL_OP_QIO;
            SFRL_C_REG: return SFRL_OP_REG;
            SFRL_C_SFDP: return SFRL_OP_SFDP;
            SFRL_C_UID: return SFRL_OP_UID;
            default: return SFRL_OP_SECQ;
        endcase
    endfunction

    // Address and data lanes: four when quad, else one
    function automatic logic sfrl_quad(sfrl_cmd_e c, logic qpi);
        return qpi || c == SFRL_C_QIO || c == SFRL_C_SECQ;
    endfunction

    function automatic logic [7:0] sfrl_cmd_cyc(logic qpi);
        return qpi ? 8'h02 : 8'h08;
    endfunction

    function automatic logic [7:0] sfrl_addr_cyc(sfrl_cmd_e c, logic qpi);
        if (c == SFRL_C_UID) return 8'h00;
        return sfrl_quad(c, qpi) ? 8'h08 : 8'h20;
    endfunction

    function automatic logic [7:0] sfrl_mode_cyc(sfrl_cmd_e c, logic qpi);
        if (c == SFRL_C_QIO) return SFRL_MODE_QUAD;
        if (c == SFRL_C_FAST4) return qpi ? SFRL_MODE_QUAD : SFRL_MODE_SINGLE;
        return 8'h00;
    endfunction

    function automatic logic [7:0] sfrl_lat_cyc(sfrl_cmd_e c, logic [3:0] code,
                                               logic [1:0] rsel, logic vol);
        if (c == SFRL_C_SFDP) return SFRL_SFDP_DUMMY;
        if (c == SFRL_C_UID) return SFRL_UID_LAT;
        if (c == SFRL_C_REG && vol) return {6'h00, rsel};
        return {4'h0, code};
    endfunction

endpackage

/* File: logic/sfrl_link_if.sv */
`timescale 1ns/1ps
interface sfrl_link_if;
    logic sck;
    logic cs_n;
    logic [3:0] dq_h;
    logic [3:0] dq_h_oe;
    logic [3:0] dq_d;
    logic [3:0] dq_d_oe;
    wire logic [3:0] dq;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        // Released lanes read high, as with a pull-up
        assign dq[i] = dq_h_oe[i] ? dq_h[i] : (dq_d_oe[i] ? dq_d[i] : 1'b1);
    end

    modport host (output sck, output cs_n, output dq_h, output dq_h_oe, input dq);
    modport device (input sck, input cs_n, input dq, output dq_d, output dq_d_oe);
endinterface

/* File: logic/sfrl_device.sv */
// Operation
// - Host keeps clock within 166/102 MHz.
// - Host reads at least two bytes.
// - Mode cycles follow address, excluded from latency.
// - Legacy quad I/O has two mode cycles.
// - More latency allows faster quad I/O.
// - Any-register read uses variable latency.
// - Discovery table read uses eight dummy cycles.
// - Unique-ID read uses 32 latency cycles.
// - Secure quad 4-4-4 read needs latency.
// - Two-bit register latency select, default 00.
`timescale 1ns/1ps
module sfrl_device
    import sfrl_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic cfg_wr_in,
    input wire logic [3:0] cfg_lat_code_in,
    input wire logic [1:0] cfg_reg_lat_in,
    input wire logic cfg_qpi_in,
    output logic [3:0] cfg_lat_code_out,
    output logic [1:0] cfg_reg_lat_out,
    output logic cfg_qpi_out,
    output logic data_start_out,
    sfrl_link_if.device link
);

    typedef enum {SFRL_PH_CMD, SFRL_PH_POST, SFRL_PH_IDLE} sfrl_dph_e;

    logic [6:0] cfg_s1_q;
    logic [6:0] cfg_s2_q;
    logic qpi;
    logic [3:0] lat_code;
    logic [1:0] reg_lat;
    sfrl_dph_e ph_q;
    logic [7:0] op_q;
    logic [7:0] op_nx;
    logic [2:0] ccnt_q;
    sfrl_cmd_e cmd_q;
    logic [31:0] addr_q;
    logic [31:0] addr_nx;
    logic [11:0] pc_q;
    logic quad;
    logic [11:0] a_end;
    logic [11:0] m_end;
    logic [11:0] l_end;
    logic [11:0] beat;
    logic [7:0] byte_idx;
    logic [7:0] data_byte;
    logic [3:0] lanes;
    logic drive_now;
    logic act_q;
    logic act_s1_q;
    logic act_s2_q;
    logic act_s3_q;
    logic cmd_last;
    sfrl_cmd_e op_cmd;
    logic [3:0] lane_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration in the reference domain

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            cfg_lat_code_out <= SFRL_LAT_RST;
            cfg_reg_lat_out <= SFRL_REGLAT_RST;
        end else if (cfg_wr_in) begin
            cfg_lat_code_out <= cfg_lat_code_in;
            cfg_reg_lat_out <= cfg_reg_lat_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            cfg_qpi_out <= SFRL_QPI_RST;
        end else if (cfg_wr_in) begin
            cfg_qpi_out <= cfg_qpi_in;
        end
    end

    // Quasi-static; the link clock only runs in frames, so a change
    // reaches this side two link edges later, i.e. in a later frame
    always_ff @(posedge link.sck) begin
        cfg_s1_q <= {cfg_qpi_out, cfg_reg_lat_out, cfg_lat_code_out};
        cfg_s2_q <= cfg_s1_q;
    end

    assign qpi = cfg_s2_q[6];
    assign reg_lat = cfg_s2_q[5:4];
    assign lat_code = cfg_s2_q[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Frame decode

    assign op_nx = qpi ? {op_q[3:0], link.dq} : {op_q[6:0], link.dq[0]};
    assign quad = sfrl_quad(cmd_q, qpi);
    assign a_end = {4'h0, sfrl_addr_cyc(cmd_q, qpi)};
    assign m_end = a_end + {4'h0, sfrl_mode_cyc(cmd_q, qpi)};
    assign addr_nx = (pc_q >= a_end) ? addr_q :
                     quad ? {addr_q[27:0], link.dq} : {addr_q[30:0], link.dq[0]};
    assign l_end = m_end + {4'h0, sfrl_lat_cyc(cmd_q, lat_code, reg_lat,
                                               addr_nx[SFRL_VOL_BIT])};

    // Drive starts on the first rise after the last latency cycle, so the
    // host has let go of the lanes half a cycle earlier even with no latency
    assign drive_now = ph_q == SFRL_PH_POST && pc_q >= l_end;
    assign beat = pc_q - l_end;
    assign lane_oe = quad ? 4'hf : 4'h2;
    assign byte_idx = quad ? beat[8:1] : beat[10:3];
    assign data_byte = addr_nx[7:0] + byte_idx;
    always_comb begin
        if (quad) begin
            lanes = beat[0] ? data_byte[3:0] : data_byte[7:4];
        end else begin
            lanes = {2'b00, data_byte[3'h7 - beat[2:0]], 1'b0};
        end
    end

    assign cmd_last = {5'h00, ccnt_q} == sfrl_cmd_cyc(qpi) - 8'h01;
    assign op_cmd = sfrl_decode(op_nx);

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            op_q <= 8'h00;
            ccnt_q <= 3'h0;
        end else if (ph_q == SFRL_PH_CMD) begin
            op_q <= op_nx;
            ccnt_q <= ccnt_q + 3'h1;
        end
    end

    // Unknown opcodes leave the lanes alone for the whole frame
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            ph_q <= SFRL_PH_CMD;
            cmd_q <= SFRL_C_BAD;
        end else if (ph_q == SFRL_PH_CMD && cmd_last) begin
            cmd_q <= op_cmd;
            ph_q <= (op_cmd == SFRL_C_BAD) ? SFRL_PH_IDLE : SFRL_PH_POST;
        end
    end

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            addr_q <= 32'h0000_0000;
        end else if (ph_q == SFRL_PH_POST) begin
            addr_q <= addr_nx;
        end
    end

    // Post-command cycle counter saturates, which caps a read near 4k cycles
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            pc_q <= 12'h000;
        end else if (ph_q == SFRL_PH_POST) begin
            if (pc_q != 12'hfff) begin
                pc_q <= pc_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data lanes

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            link.dq_d <= 4'h0;
            link.dq_d_oe <= 4'h0;
        end else if (drive_now) begin
            link.dq_d <= lanes;
            link.dq_d_oe <= lane_oe;
        end
    end

    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            act_q <= 1'b0;
        end else if (drive_now) begin
            act_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-start event back to the reference domain

    // Level cleared by chip select, so it needs no link edge to fall
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            act_s1_q <= 1'b0;
            act_s2_q <= 1'b0;
            act_s3_q <= 1'b0;
        end else begin
            act_s1_q <= act_q;
            act_s2_q <= act_s1_q;
            act_s3_q <= act_s2_q;
        end
    end

    // One pulse per frame, on the rise of the synchronised level
    always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
            data_start_out <= 1'b0;
        end else begin
            data_start_out <= act_s2_q & ~act_s3_q;
        end
    end

endmodule

/* File: tb/sfrl_link_chk.sv */
`timescale 1ns/1ps
module sfrl_link_chk (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] dq_h,
    input wire logic [3:0] dq_h_oe,
    input wire logic [3:0] dq_d_oe
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    ////////////////////////////////////////////////////////////////////////////
    AST_SCK_IDLE_LOW: assert property (
        cs_n |-> !sck) else $error("link clock not low while deselected");
    AST_SCK_HALF_PERIOD: assert property (
        $changed(sck) |=> $stable(sck)) else $error("link clock half period too short");
    AST_SCK_KEEPS_RUNNING: assert property (
        !cs_n |-> ##[1:2] ($changed(sck) || cs_n)) else $error("link clock stalled in frame");
    AST_NO_CONTENTION: assert property (
        (|dq_d_oe) |-> (dq_h_oe == 4'h0)) else $error("both ends drive the data lines");
    AST_DEV_QUIET_IDLE: assert property (
        cs_n |-> (dq_d_oe == 4'h0)) else $error("device drives while deselected");
    AST_DEV_LANES: assert property (
        (|dq_d_oe) |-> (dq_d_oe == 4'h2 || dq_d_oe == 4'hf)) else $error("bad device lanes");
    // Once data starts the device must not let go until deselect
    AST_DEV_DRIVE_HOLDS: assert property (
        !cs_n && $past(|dq_d_oe) |-> (dq_d_oe == $past(dq_d_oe)))
        else $error("device drive changed in frame");
    AST_HOST_DQ_ON_FALL: assert property (
        !cs_n && $past(!cs_n) && $changed(dq_h) |-> $fell(sck))
        else $error("host data changed away from clock fall");
    AST_CS_GAP: assert property (
        $rose(cs_n) |-> cs_n[*8]) else $error("deselect gap too short");

    cover property ($rose(|dq_d_oe));
    cover property (dq_d_oe == 4'hf);
    cover property ($rose(cs_n));
endmodule

/* File: tb/serial_flash_read_latency_tb.sv */
`timescale 1ns/1ps
module serial_flash_read_latency_tb;
    import sfrl_pkg::*;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cfg_wr = 1'b0, start = 1'b0, qpi = 1'b0;
    logic [3:0] code = 4'h8;
    logic [1:0] rsel = 2'h0;
    sfrl_cmd_e cmd = SFRL_C_FAST4;
    logic [31:0] addr = 32'h0;
    logic [7:0] nbytes = 8'h02;
    logic [3:0] lat_o;
    logic [1:0] rsel_o;
    logic qpi_o, dstart, busy, refused, rx_valid, done;
    logic [7:0] rx_data;
    int num_errors = 0, check_count = 0, rises = 0, lat_seen = 0, frames = 0, ds_cnt = 0;
    logic seen = 1'b0;
    integer seed = 32'he556;
    logic [31:0] ra;

    always #2.5 ref_clk_in = ~ref_clk_in;

    sfrl_link_if sfrl_link_if_i ();
    sfrl_device sfrl_device_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .cfg_wr_in(cfg_wr), .cfg_lat_code_in(code), .cfg_reg_lat_in(rsel),
        .cfg_qpi_in(qpi), .cfg_lat_code_out(lat_o), .cfg_reg_lat_out(rsel_o),
        .cfg_qpi_out(qpi_o), .data_start_out(dstart), .link(sfrl_link_if_i));
    sfrl_host sfrl_host_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .start_in(start), .cmd_in(cmd), .addr_in(addr), .nbytes_in(nbytes),
        .qpi_in(qpi), .lat_code_in(code), .reg_lat_in(rsel), .busy_out(busy),
        .refused_out(refused), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
        .done_out(done), .link(sfrl_link_if_i));
    sfrl_link_chk sfrl_link_chk_i (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
        .sck(sfrl_link_if_i.sck), .cs_n(sfrl_link_if_i.cs_n), .dq_h(sfrl_link_if_i.dq_h),
        .dq_h_oe(sfrl_link_if_i.dq_h_oe), .dq_d_oe(sfrl_link_if_i.dq_d_oe));

    ////////////////////////////////////////////////////////////////////////////
    // Link monitor: clock rises up to and including the one on which the device first drives
    always @(negedge sfrl_link_if_i.cs_n) begin
        rises = 0;
        seen = 1'b0;
        frames++;
    end
    always @(posedge sfrl_link_if_i.sck) if (!sfrl_link_if_i.cs_n) rises++;
    always @(sfrl_link_if_i.dq_d_oe) begin
        if (|sfrl_link_if_i.dq_d_oe && !seen) begin
            lat_seen = rises;
            seen = 1'b1;
        end
    end
    always @(posedge ref_clk_in) if (dstart === 1'b1) ds_cnt++;

    ////////////////////////////////////////////////////////////////////////////
    function automatic int exp_rises(sfrl_cmd_e c, logic q, logic [31:0] a);
        int n;
        logic quad;
        quad = q || c == SFRL_C_QIO || c == SFRL_C_SECQ;
        n = q ? 2 : 8;
        if (c != SFRL_C_UID) n += quad ? 8 : 32;
        if (c == SFRL_C_QIO) n += 2;
        else if (c == SFRL_C_FAST4) n += q ? 2 : 8;
        case (c)
            SFRL_C_SFDP: n += 8;
            SFRL_C_UID: n += 32;
            SFRL_C_REG: n += a[23] ? int'(rsel) : int'(code);
            default: n += int'(code);
        endcase
        // Data starts on the first rise after the latency
        return n + 1;
    endfunction

    function automatic logic exp_refuse(sfrl_cmd_e c);
        return c == SFRL_C_BAD || (code == 4'h0 && (c == SFRL_C_QIO || (c == SFRL_C_SECQ && qpi)));
    endfunction

    task automatic check_num(logic [15:0] got, logic [15:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(logic got, logic exp, string what);
        check_num({15'h0, got}, {15'h0, exp}, what);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic timeout(string what);
        num_errors++;
        $display("Error at %0t: timeout waiting for %s", $time, what);
        tally_and_finish();
    endtask

    task automatic do_read(sfrl_cmd_e c, logic [31:0] a, logic [7:0] n, logic chk);
        int i, got, f0;
        logic fin, was_ref, rexp;
        got = 0;
        fin = 1'b0;
        was_ref = 1'b0;
        rexp = exp_refuse(c);
        f0 = frames;
        ds_cnt = 0;
        @(posedge ref_clk_in);
        cmd <= c;
        addr <= a;
        nbytes <= n;
        start <= 1'b1;
        @(posedge ref_clk_in);
        start <= 1'b0;
        for (i = 0; i < 4000 && !fin; i++) begin
            @(posedge ref_clk_in);
            if (rx_valid === 1'b1) begin
                if (chk) check_num({8'h0, rx_data}, {8'h0, (c == SFRL_C_UID) ?
                    8'(got) : a[7:0] + 8'(got)}, "data byte");
                got++;
            end
            if (refused === 1'b1) was_ref = 1'b1;
            if (refused === 1'b1 || done === 1'b1) fin = 1'b1;
        end
        if (!fin) timeout("frame end");
        for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge ref_clk_in);
        if (busy !== 1'b0) timeout("idle");
        if (chk) begin
            check_bit(was_ref, rexp, "refusal");
            check_num(16'(frames - f0), rexp ? 16'h0 : 16'h1, "frames");
            check_num(16'(got), rexp ? 16'h0 : ((n < 2) ? 16'h2 : {8'h0, n}), "bytes");
            if (!rexp) begin
                check_num(16'(lat_seen), 16'(exp_rises(c, qpi, a)), "latency");
                check_num(16'(ds_cnt), 16'h1, "data start");
            end
        end
    endtask

    task automatic do_cfg(logic [3:0] lc, logic [1:0] rs, logic q);
        @(posedge ref_clk_in);
        cfg_wr <= 1'b1;
        code <= lc;
        rsel <= rs;
        qpi <= q;
        @(posedge ref_clk_in);
        cfg_wr <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        check_num({10'h0, lat_o, rsel_o}, {10'h0, lc, rs}, "config");
        check_bit(qpi_o, q, "config qpi");
        // New setting lands only after a few link edges
        do_read(SFRL_C_FAST4, 32'h0, 8'h2, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    logic [6:0] corners [4] = '{7'h00, 7'h01, 7'h7e, 7'h0d};
    initial begin
        repeat (8) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        check_num({9'h0, lat_o, rsel_o, qpi_o},
            {9'h0, SFRL_LAT_RST, SFRL_REGLAT_RST, SFRL_QPI_RST}, "reset config");
        do_read(SFRL_C_BAD, 32'h0, 8'h2, 1'b1);
        for (int r = 0; r < 8; r++) begin
            if (r < 4) do_cfg(corners[r][6:3], corners[r][2:1], corners[r][0]);
            else do_cfg(4'($random(seed)), 2'($random(seed)), 1'($random(seed)));
            for (int k = 0; k < 6; k++) begin
                ra = $random(seed);
                if (r == 2) ra[7:0] = 8'hff;
                do_read(sfrl_cmd_e'(k), ra, 8'($random(seed)) & 8'h07, 1'b1);
            end
        end
        tally_and_finish();
    end
endmodule
